//--- hdl/rsw_consts.vh
/*
 * Constants for the ring status word block: register addresses, bit positions,
 * reset values and timing counts.
 * Assumes it is included by bare name from the hdl folder.
 */
`ifndef RSW_CONSTS_VH
`define RSW_CONSTS_VH

// ----------------------------------------------------------------
// local bus addresses
// ----------------------------------------------------------------
`define RSW_ADDR_CTRL0         4'h0
`define RSW_ADDR_CMD_CLEAR     4'h1
`define RSW_ADDR_STATUS        4'h2
`define RSW_ADDR_STATUS1       4'h3
`define RSW_ADDR_TX_FIFO       4'h4
`define RSW_ADDR_RET_FIFO      4'h5
`define RSW_ADDR_RX_FIFO       4'h6

// ----------------------------------------------------------------
// control word bits
// ----------------------------------------------------------------
`define RSW_CTRL_ENABLE        0
`define RSW_CTRL_SEND          1
`define RSW_CTRL_REPLAY        2
`define RSW_CLR_IRQ            0

// ----------------------------------------------------------------
// status word bits
// ----------------------------------------------------------------
`define RSW_ST_TX_RUN          0
`define RSW_ST_RX_RUN          1
`define RSW_ST_RX_HALF         2
`define RSW_ST_RX_FULL         3
`define RSW_ST_RX_EMPTY        4
`define RSW_ST_RET_HALF        5
`define RSW_ST_RET_FULL        6
`define RSW_ST_RET_EMPTY       7
`define RSW_ST_TX_HALF         8
`define RSW_ST_TX_FULL         9
`define RSW_ST_TX_EMPTY        10
`define RSW_ST_LINK_UP         11
`define RSW_ST_IRQ             12
`define RSW_ST_FOR_CTRL        13
`define RSW_ST_TIMING_READY    14
`define RSW_ST_SPARE           15
`define RSW_S1_CLR_MSB         6
`define RSW_S1_CLR_LSB         3

// ----------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------
`define RSW_RESET_WORD         16'h0000
`define RSW_EMPTY_READ         16'hFFFF
`define RSW_IDLE_BYTES         512

`endif

//--- hdl/rsw_status_word.v
/*
 * Status word of the ring controller, local bus register file at address 2,
 * with the command clear register, controller enable / send / replay controls,
 * and the host FIFO access gating tied to controller_enable.
 * Assumes FIFO flags, receive and transmit engine strobes are on clk; the
 * timing receiver lock arrives from a pin and is synchronised here.
 */
//
// Behaviour
// - status word is read-only at local address 2; writes ignored.
// - bit 14 follows the timing receiver lock.
// - bit 13 sets when last byte of a frame for the controller lands.
// - frames for the controller go to receive and return FIFOs.
// - bit 13 holds until command clear bit 0 is written one.
// - interrupt line raised on any last received byte; bit 12 mirrors it.
// - interrupt and bit 12 hold until command clear bit 0 written one.
// - bit 11 low until 512 idle bytes sent and first token returned.
// - bits 10..8 show transmit FIFO flags; empty read gives FFFF.
// - bits 7..5 show return FIFO flags; empty read gives FFFF.
// - bits 4..2 show receive FIFO flags; empty read gives FFFF.
// - bit 1 high while frame data enters the receive FIFO.
// - bit 0 high from enabled send/replay until FIFO empty and end sent.
// - enable allows transmit and blocks listed host FIFO accesses.
// - send toggle starts transmit; replay toggle also rewinds read pointer.
// - clear bit 0 clears bits 13,12 and status-1 bits 6..3; self-clears.
//
`timescale 1ns/1ps
`default_nettype none
`include "rsw_consts.vh"

module rsw_status_word #(
    parameter IDLE_BYTES = `RSW_IDLE_BYTES
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // local bus
    input  wire [3:0]  lb_addr,
    input  wire        lb_wr,
    input  wire        lb_rd,
    input  wire [15:0] lb_wdata,
    output reg  [15:0] lb_rdata,
    output reg         lb_rvalid,
    // host fifo port gates
    output reg         tx_fifo_wr,
    output reg         tx_fifo_rd_host,
    output reg         ret_fifo_wr_host,
    output reg         ret_fifo_rd_host,
    output reg         rx_fifo_wr_host,
    output reg         rx_fifo_rd,
    output reg  [15:0] fifo_wdata,
    input  wire [15:0] tx_fifo_dout,
    input  wire [15:0] ret_fifo_dout,
    input  wire [15:0] rx_fifo_dout,
    // fifo flags, active high
    input  wire [2:0]  tx_flags,
    input  wire [2:0]  ret_flags,
    input  wire [2:0]  rx_flags,
    // timing receiver lock, from pin
    input  wire        timing_receiver_ready,
    // receive engine
    input  wire        rx_byte_wr,
    input  wire        rx_last_byte,
    input  wire        rx_for_ctrl,
    input  wire [6:0]  status1_in,
    // transmit engine
    input  wire        idle_byte_sent,
    input  wire        token_seen,
    input  wire        tx_eof_sent,
    output reg         tx_go,
    output reg         tx_rewind,
    output reg         ret_copy_wr,
    output reg         local_irq,
    output reg  [6:0]  status1_q
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg         ctrl_enable_q;
    reg         send_q;
    reg         replay_q;
    reg         for_ctrl_q;
    reg         link_up_q;
    reg         idle_done_q;
    reg  [9:0]  idle_cnt_q;
    reg         tx_run_q;
    reg         rx_run_q;
    wire        ready_s;

    wire wr_ctrl  = lb_wr && (lb_addr == `RSW_ADDR_CTRL0);
    wire clr_hit  = lb_wr && (lb_addr == `RSW_ADDR_CMD_CLEAR) && lb_wdata[`RSW_CLR_IRQ];
    wire rx_done  = rx_byte_wr && rx_last_byte;
    wire send_tg  = wr_ctrl && (lb_wdata[`RSW_CTRL_SEND] != send_q);
    wire rep_tg   = wr_ctrl && (lb_wdata[`RSW_CTRL_REPLAY] != replay_q);
    wire en_next  = wr_ctrl ? lb_wdata[`RSW_CTRL_ENABLE] : ctrl_enable_q;

    rsw_sync2 #(
        .WIDTH (1)
    ) u_ready_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (timing_receiver_ready),
        .sync_out (ready_s)
    );

    // ----------------------------------------------------------------
    // control and events
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_enable_q <= 1'b0;
            send_q        <= 1'b0;
            replay_q      <= 1'b0;
            for_ctrl_q    <= 1'b0;
            local_irq     <= 1'b0;
            status1_q     <= 7'h00;
            link_up_q     <= 1'b0;
            idle_done_q   <= 1'b0;
            idle_cnt_q    <= 10'h000;
            tx_run_q      <= 1'b0;
            rx_run_q      <= 1'b0;
            tx_go         <= 1'b0;
            tx_rewind     <= 1'b0;
            ret_copy_wr   <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_enable_q <= lb_wdata[`RSW_CTRL_ENABLE];
                send_q        <= lb_wdata[`RSW_CTRL_SEND];
                replay_q      <= lb_wdata[`RSW_CTRL_REPLAY];
            end
            // enable must be set before or with the toggle
            tx_go     <= en_next && (send_tg || rep_tg);
            tx_rewind <= en_next && rep_tg;
            // copy of controller frames into the return FIFO
            ret_copy_wr <= rx_byte_wr && rx_for_ctrl;
            // set wins over a clear in the same cycle
            if (rx_done && rx_for_ctrl)
                for_ctrl_q <= 1'b1;
            else if (clr_hit)
                for_ctrl_q <= 1'b0;
            if (rx_done)
                local_irq <= 1'b1;
            else if (clr_hit)
                local_irq <= 1'b0;
            status1_q <= status1_in;
            if (clr_hit)
                status1_q[`RSW_S1_CLR_MSB:`RSW_S1_CLR_LSB] <= 4'h0;
            // link bring-up: idle bytes counted, then first token
            if (idle_byte_sent && !idle_done_q)
            begin
                if (idle_cnt_q == IDLE_BYTES - 1)
                    idle_done_q <= 1'b1;
                idle_cnt_q <= idle_cnt_q + 10'h001;
            end
            if (idle_done_q && token_seen)
                link_up_q <= 1'b1;
            rx_run_q <= rx_byte_wr && !rx_last_byte;
            if (en_next && (send_tg || rep_tg))
                tx_run_q <= 1'b1;
            else if (tx_eof_sent && tx_flags[2])
                tx_run_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // host fifo access gating and read mux
    // ----------------------------------------------------------------
    wire [15:0] status_word = {1'b0,
                               ready_s,
                               for_ctrl_q,
                               local_irq,
                               link_up_q,
                               tx_flags,
                               ret_flags,
                               rx_flags,
                               rx_run_q,
                               tx_run_q};

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            lb_rdata         <= `RSW_RESET_WORD;
            lb_rvalid        <= 1'b0;
            tx_fifo_wr       <= 1'b0;
            tx_fifo_rd_host  <= 1'b0;
            ret_fifo_wr_host <= 1'b0;
            ret_fifo_rd_host <= 1'b0;
            rx_fifo_wr_host  <= 1'b0;
            rx_fifo_rd       <= 1'b0;
            fifo_wdata       <= 16'h0000;
        end
        else
        begin
            fifo_wdata       <= lb_wdata;
            tx_fifo_wr       <= lb_wr && (lb_addr == `RSW_ADDR_TX_FIFO);
            // enable blocks these host paths
            ret_fifo_wr_host <= lb_wr && (lb_addr == `RSW_ADDR_RET_FIFO) && !ctrl_enable_q;
            rx_fifo_wr_host  <= lb_wr && (lb_addr == `RSW_ADDR_RX_FIFO) && !ctrl_enable_q;
            tx_fifo_rd_host  <= lb_rd && (lb_addr == `RSW_ADDR_TX_FIFO) && !ctrl_enable_q
                                && !tx_flags[2];
            ret_fifo_rd_host <= lb_rd && (lb_addr == `RSW_ADDR_RET_FIFO) && !ctrl_enable_q
                                && !ret_flags[2];
            rx_fifo_rd       <= lb_rd && (lb_addr == `RSW_ADDR_RX_FIFO) && !rx_flags[2];
            lb_rvalid        <= lb_rd;
            // writes to the status address fall through to nothing
            case (lb_addr)
                `RSW_ADDR_CTRL0:
                    lb_rdata <= {13'h0000, replay_q, send_q, ctrl_enable_q};
                `RSW_ADDR_STATUS:
                    lb_rdata <= status_word;
                `RSW_ADDR_STATUS1:
                    lb_rdata <= {9'h000, status1_q};
                `RSW_ADDR_TX_FIFO:
                    lb_rdata <= (tx_flags[2] || ctrl_enable_q) ? `RSW_EMPTY_READ
                                : tx_fifo_dout;
                `RSW_ADDR_RET_FIFO:
                    lb_rdata <= (ret_flags[2] || ctrl_enable_q) ? `RSW_EMPTY_READ
                                : ret_fifo_dout;
                `RSW_ADDR_RX_FIFO:
                    lb_rdata <= rx_flags[2] ? `RSW_EMPTY_READ : rx_fifo_dout;
                default:
                    lb_rdata <= 16'h0000;
            endcase
        end
    end

endmodule

`default_nettype wire

//--- hdl/rsw_sync2.v
/*
 * Two-flop synchroniser for a bundle of level signals.
 * Assumes inputs come from another clock domain or a pin; output is a clean level.
 */
`timescale 1ns/1ps
`default_nettype none

module rsw_sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

//--- testbench/rsw_chk.sv
/* rsw_chk: port assertions for the ring status word block.
   Assumes it is bound into rsw_status_word and sees one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module rsw_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // local bus
    input wire logic [3:0]  lb_addr,
    input wire logic        lb_wr,
    input wire logic        lb_rd,
    input wire logic [15:0] lb_wdata,
    input wire logic [15:0] lb_rdata,
    input wire logic        lb_rvalid,
    // flags and engines
    input wire logic [2:0]  tx_flags,
    input wire logic [2:0]  ret_flags,
    input wire logic [2:0]  rx_flags,
    input wire logic        rx_byte_wr,
    input wire logic        rx_last_byte,
    input wire logic        rx_for_ctrl,
    input wire logic        ret_copy_wr,
    input wire logic        local_irq,
    input wire logic [6:0]  status1_q
);
    wire [8:0] fl   = {tx_flags, ret_flags, rx_flags};
    wire       clr  = lb_wr && lb_addr == 4'h1 && lb_wdata[0];
    wire       last = rx_byte_wr && rx_last_byte;
    wire       rxb  = rx_byte_wr && !rx_last_byte;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    rd_answer_a: assert property (lb_rd |=> lb_rvalid) else $error("no read answer");
    spare_zero_a: assert property (lb_rvalid && $past(lb_addr) == 4'h2 |-> !lb_rdata[15])
        else $error("spare bit set");
    // flags held two cycles so either pipelining choice reads the same value
    fifo_flags_a: assert property (lb_rvalid && $past(lb_addr) == 4'h2
        && $past(fl, 2) == $past(fl) |-> lb_rdata[10:2] == $past(fl)) else $error("flags wrong");
    irq_set_a: assert property (last |=> local_irq) else $error("irq not raised");
    rx_run_a: assert property (lb_rvalid && $past(lb_addr) == 4'h2
        |-> lb_rdata[1] == $past(rxb, 2)) else $error("receive bit wrong");
    irq_bit_a: assert property (lb_rvalid && $past(lb_addr) == 4'h2
        |-> lb_rdata[12] == $past(local_irq)) else $error("irq bit differs");
    irq_hold_a: assert property (local_irq && !clr |=> local_irq) else $error("irq lost");
    irq_clear_a: assert property (clr && !last |=> !local_irq) else $error("irq kept");
    ret_copy_a: assert property (rx_byte_wr && rx_for_ctrl |=> ret_copy_wr)
        else $error("no return copy");
    status1_clr_a: assert property (clr |=> status1_q[6:3] == 4'h0)
        else $error("status1 not cleared");
    cover property (last ##1 local_irq);
    cover property (ret_copy_wr);
    cover property (lb_rvalid && lb_rdata[11]);
endmodule
bind rsw_status_word rsw_chk chk (.*);
`default_nettype wire

//--- testbench/rsw_ring_model.sv
/* rsw_ring_model: receive engine on the ring side, emits one frame of bytes.
   Assumes start is driven non-blocking on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module rsw_ring_model (
    // clock
    input  wire logic       clk,
    // frame request
    input  wire logic       start,
    input  wire logic       for_ctrl,
    input  wire logic [3:0] len,
    // receive strobes
    output logic            rx_byte_wr,
    output logic            rx_last_byte,
    output logic            rx_for_ctrl
);
    logic [3:0] left_q;
    initial {rx_byte_wr, rx_last_byte, rx_for_ctrl, left_q} = '0;
    // qualifiers wander between frames, the design must gate them
    always @(negedge clk)
    begin
        rx_byte_wr   <= left_q != 4'h0;
        rx_last_byte <= (left_q != 4'h0) ? left_q == 4'h1 : ~rx_last_byte;
        rx_for_ctrl  <= start ? for_ctrl : ((left_q != 4'h0) ? rx_for_ctrl : ~rx_for_ctrl);
        left_q       <= start ? len : ((left_q != 4'h0) ? left_q - 4'h1 : 4'h0);
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
/* tb: self-checking bench for the ring status word block.
   Assumes the checker is bound in and the ring model drives the receive strobes. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin miscompares++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module tb;
    localparam int IDLE = 4;
    logic        clk, rst_n, lb_wr, lb_rd, rx_go, rx_ctl, timing_receiver_ready;
    logic [2:0]  ev, tx_flags, ret_flags, rx_flags;
    logic [3:0]  lb_addr, rx_len;
    logic [15:0] lb_wdata, lb_rdata, tx_fifo_dout, ret_fifo_dout, rx_fifo_dout, e, fifo_wdata;
    logic [6:0]  status1_in;
    logic        lb_rvalid, tx_go, tx_rewind, local_irq, ret_fifo_wr_host, rx_fifo_wr_host;
    logic        rx_byte_wr, rx_last_byte, rx_for_ctrl, forc, irq, link, txrun;
    logic        tx_fifo_wr, tx_fifo_rd_host, ret_fifo_rd_host, rx_fifo_rd;
    int          checked = 0, miscompares = 0, go_n = 0, rew_n = 0, hw_n = 0;
    int          rd_n = 0, tw_n = 0, nrd = 0;
    logic [15:0] q[$];
    rsw_status_word #(.IDLE_BYTES(IDLE)) uut (
        .clk, .rst_n, .lb_addr, .lb_wr, .lb_rd, .lb_wdata, .lb_rdata, .lb_rvalid,
        .tx_fifo_wr, .tx_fifo_rd_host, .ret_fifo_wr_host, .ret_fifo_rd_host,
        .rx_fifo_wr_host, .rx_fifo_rd, .fifo_wdata, .tx_fifo_dout, .ret_fifo_dout,
        .rx_fifo_dout, .tx_flags, .ret_flags, .rx_flags, .timing_receiver_ready,
        .rx_byte_wr, .rx_last_byte, .rx_for_ctrl, .status1_in, .idle_byte_sent(ev[2]),
        .token_seen(ev[1]), .tx_eof_sent(ev[0]), .tx_go, .tx_rewind, .ret_copy_wr(),
        .local_irq, .status1_q());
    rsw_ring_model ring (.clk, .start(rx_go), .for_ctrl(rx_ctl), .len(rx_len),
        .rx_byte_wr, .rx_last_byte, .rx_for_ctrl);
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [15:0] sw();
        return {1'b0, timing_receiver_ready, forc, irq, link, tx_flags, ret_flags, rx_flags,
            1'b0, txrun};
    endfunction
    task rd(input logic [3:0] a, input logic [15:0] x);
        @(negedge clk);
        lb_addr = a;
        lb_rd = 1'b1;
        q.push_back(x);
        @(negedge clk);
        lb_rd = 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clk);
        lb_addr = a;
        lb_wdata = d;
        lb_wr = 1'b1;
        @(negedge clk);
        lb_wr = 1'b0;
    endtask
    task ev_pulse(input logic [2:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 3'b000;
    endtask
    task settle();
        repeat (4) @(negedge clk);
    endtask
    // model reads start on the same edge, hence non-blocking
    task frame(input logic c, input logic [3:0] n);
        rx_ctl = c;
        rx_len = n;
        @(negedge clk);
        rx_go <= 1'b1;
        @(negedge clk);
        rx_go <= 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(negedge clk)
    begin
        go_n += int'(tx_go === 1'b1);
        rew_n += int'(tx_rewind === 1'b1);
        hw_n += int'(ret_fifo_wr_host === 1'b1 || rx_fifo_wr_host === 1'b1);
        rd_n += int'(tx_fifo_rd_host === 1'b1 || ret_fifo_rd_host === 1'b1 || rx_fifo_rd === 1'b1);
        if (tx_fifo_wr === 1'b1)
        begin
            tw_n++;
            `CHK("fifo write data", lb_wdata, fifo_wdata)
        end
        if (lb_rvalid === 1'b1)
        begin
            e = (q.size() > 0) ? q.pop_front() : 16'hxxxx;
            `CHK("read data", e, lb_rdata)
        end
    end
    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h00d6_298c));
        {rst_n, lb_wr, lb_rd, rx_go, rx_ctl, ev, timing_receiver_ready, forc, irq} = '0;
        {lb_addr, rx_len, lb_wdata, status1_in, link, txrun} = '0;
        {tx_fifo_dout, ret_fifo_dout, rx_fifo_dout} = '0;
        {tx_flags, ret_flags, rx_flags} = 9'h124;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            {tx_flags, ret_flags, rx_flags, timing_receiver_ready} = 10'($urandom);
            {status1_in, tx_fifo_dout} = 23'($urandom);
            {ret_fifo_dout, rx_fifo_dout} = $urandom;
            settle();
            rd(4'h2, sw());
            rd(4'h3, {9'h000, status1_in});
            nrd += int'(!rx_flags[2]);
            rd(4'h6, rx_flags[2] ? 16'hffff : rx_fifo_dout);
        end
        wr(4'h2, 16'($urandom));
        rd(4'h2, sw());
        rd(4'h7, 16'h0000);
        {tx_flags, ret_flags, rx_flags} = 9'h124;
        settle();
        rd(4'h4, 16'hffff);
        rd(4'h5, 16'hffff);
        rd(4'h6, 16'hffff);
        frame(1'b1, 4'h3);
        {irq, forc} = 2'b11;
        `CHK("irq line", 1'b1, local_irq)
        rd(4'h2, sw());
        wr(4'h1, 16'h0001);
        {irq, forc} = 2'b00;
        rd(4'h2, sw());
        frame(1'b0, 4'h1);
        irq = 1'b1;
        rd(4'h2, sw());
        wr(4'h1, 16'h0001);
        irq = 1'b0;
        // early token must not bring the link up
        repeat (IDLE - 1) ev_pulse(3'b100);
        ev_pulse(3'b010);
        settle();
        rd(4'h2, sw());
        ev_pulse(3'b100);
        ev_pulse(3'b010);
        link = 1'b1;
        settle();
        rd(4'h2, sw());
        {tx_flags, ret_flags} = 6'b000000;
        wr(4'h0, 16'h0002);
        wr(4'h0, 16'h0000);
        `CHK("send while disabled", 0, go_n)
        wr(4'h0, 16'h0001);
        wr(4'h0, 16'h0003);
        settle();
        txrun = 1'b1;
        `CHK("send pulses", 1, go_n)
        rd(4'h2, sw());
        rd(4'h0, 16'h0003);
        rd(4'h5, 16'hffff);
        wr(4'h4, 16'($urandom));
        wr(4'h5, 16'h00aa);
        wr(4'h6, 16'h0055);
        settle();
        `CHK("blocked writes", 0, hw_n)
        `CHK("transmit writes", 1, tw_n)
        tx_flags = 3'b100;
        settle();
        ev_pulse(3'b001);
        settle();
        txrun = 1'b0;
        rd(4'h2, sw());
        // refill only once transmit has gone idle
        tx_flags = 3'b000;
        wr(4'h0, 16'h0007);
        settle();
        txrun = 1'b1;
        `CHK("replay rewinds", 1, rew_n)
        rd(4'h2, sw());
        wr(4'h0, 16'h0006);
        wr(4'h6, 16'h0055);
        settle();
        `CHK("host write disabled", 1, hw_n)
        `CHK("fifo read pulses", nrd, rd_n)
        for (int i = 0; i < 20 && q.size() > 0; i++) @(negedge clk);
        if (q.size() > 0)
            miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
